// [bench/svrf_assertions.sv]
// Purpose: Port checks for the vector register file.
// Assumes: Both units present.
// Notes: Bound to every register file instance.
`timescale 1ns/1ns
`default_nettype none
module svrf_assertions
	import svrf_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire svrf_bus_s   bus,
	input wire logic [31:0] bus_rdata,
	input wire svrf_vrd_s   vrd,
	input wire svrf_rsp_s   vrd_rsp,
	input wire svrf_fp_s    fp,
	input wire logic        fp_rd_valid,
	input wire logic        issue_valid,
	input wire logic        exc_valid,
	input wire logic        exc_reserved,
	input wire logic        exc_disabled,
	input wire logic        big_endian_flag,
	input wire logic        fpu_wide_reg_mode,
	input wire logic        regs_undefined
);
	// One clock domain; nothing is judged while reset is low.
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_cap; bus.rd && bus.addr == ADDR_CAP |=> bus_rdata[28] && bus_rdata[22]; endproperty
	a_cap: assert property (p_cap) else $error("capability bits low");
	property p_ieee; bus.rd && bus.addr == ADDR_CAP |=> &bus_rdata[19:18]; endproperty
	a_ieee: assert property (p_ieee) else $error("compliance bits low");
	property p_vv; vrd_rsp.valid == $past(vrd.en); endproperty
	a_vv: assert property (p_vv) else $error("read answer slot wrong");
	property p_word; vrd.en && vrd.fmt == FMT_WORD |=>
		vrd_rsp.elem == {32'h0, vrd_rsp.vec[$past(vrd.idx[1:0])*32 +: 32]}; endproperty
	a_word: assert property (p_word) else $error("word element misplaced");
	property p_byte; vrd.en && vrd.fmt == FMT_BYTE |=>
		vrd_rsp.elem == {56'h0, vrd_rsp.vec[$past(vrd.idx)*8 +: 8]}; endproperty
	a_byte: assert property (p_byte) else $error("byte element misplaced");
	property p_le; vrd.en && !big_endian_flag |=> vrd_rsp.mem == vrd_rsp.vec; endproperty
	a_le: assert property (p_le) else $error("little image wrong");
	property p_be; vrd.en && vrd.fmt == FMT_WORD && big_endian_flag |=>
		vrd_rsp.mem[7:0] == vrd_rsp.vec[31:24]; endproperty
	a_be: assert property (p_be) else $error("big image wrong");
	// Back-to-back scalar reads are legal, so the answer pulse tracks each request.
	property p_fpv; fp_rd_valid == $past(fp.rd); endproperty
	a_fpv: assert property (p_fpv) else $error("scalar read slot wrong");
	property p_wide; issue_valid && fpu_wide_reg_mode |=> exc_valid && !exc_reserved; endproperty
	a_wide: assert property (p_wide) else $error("reserved in wide mode");
	property p_excl; exc_valid |-> !(exc_reserved && exc_disabled); endproperty
	a_excl: assert property (p_excl) else $error("both exceptions");
	property p_und; $changed(fpu_wide_reg_mode) |-> ##[0:1] regs_undefined; endproperty
	a_und: assert property (p_und) else $error("mode change not flagged");
	c_be: cover property (vrd_rsp.valid && big_endian_flag);
	c_res: cover property (exc_valid && exc_reserved);
	c_dis: cover property (exc_valid && exc_disabled);
endmodule // svrf_assertions
bind svrf_vector_regfile svrf_assertions u_chk (.core_clk, .rst_n, .bus, .bus_rdata,
	.vrd, .vrd_rsp, .fp, .fp_rd_valid, .issue_valid, .exc_valid, .exc_reserved,
	.exc_disabled, .big_endian_flag, .fpu_wide_reg_mode, .regs_undefined);
`default_nettype wire

// [bench/svrf_partner.sv]
// Purpose: Pipeline, FPU and load/store side of the register file.
// Assumes: Calls start just after a rising core_clk edge.
// Notes: Dropped requests show inverted fields, never stale ones.
`timescale 1ns/1ns
`default_nettype none
module svrf_partner
	import svrf_pkg::*;
(
	input  wire logic      core_clk,
	output var  svrf_vwr_s vwr,
	output var  svrf_vrd_s vrd,
	output var  svrf_ld_s  lsu_ld,
	output var  svrf_fp_s  fp,
	output var  logic      issue_valid
);
	// Each request stands for one taking edge, then its strobe drops.
	task automatic vw(input svrf_vwr_s r);
		@(posedge core_clk);
		vwr <= r;
		@(posedge core_clk);
		vwr <= {1'b0, ~r[$bits(r)-2:0]};
	endtask
	task automatic vr(input svrf_vrd_s r);
		@(posedge core_clk);
		vrd <= r;
		@(posedge core_clk);
		vrd <= {1'b0, ~r[$bits(r)-2:0]};
	endtask
	task automatic ld(input svrf_ld_s r);
		@(posedge core_clk);
		lsu_ld <= r;
		@(posedge core_clk);
		lsu_ld <= {1'b0, ~r[$bits(r)-2:0]};
	endtask
	task automatic fo(input svrf_fp_s r);
		@(posedge core_clk);
		fp <= r;
		@(posedge core_clk);
		fp <= {2'b00, ~r[$bits(r)-3:0]};
	endtask
	task automatic iss();
		@(posedge core_clk);
		issue_valid <= 1'b1;
		@(posedge core_clk);
		issue_valid <= 1'b0;
	endtask
	// Idle until the bench asks for traffic.
	initial begin
		vwr = '0;
		vrd = '0;
		lsu_ld = '0;
		fp = '0;
		issue_valid = 1'b0;
	end
endmodule // svrf_partner
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the vector register file.
// Assumes: Both units present; 100 MHz core clock.
// Notes: Every wait is a fixed answer slot, so nothing can hang.
`timescale 1ns/1ns
`default_nettype none
module tb
	import svrf_pkg::*;
;
	logic         core_clk = 1'b0;
	logic         rst_n = 1'b0;
	svrf_bus_s    bus = '0;
	logic [31:0]  bus_rdata;
	svrf_vwr_s    vwr;
	svrf_vrd_s    vrd;
	svrf_rsp_s    rsp;
	svrf_ld_s     ld;
	svrf_fp_s     fp;
	logic [63:0]  fpd;
	logic         fpv, iv, exv, exr, exd, bef, frm, und;
	logic [127:0] d, e;
	logic [31:0]  cv [4] = '{32'h0, 32'h0800_0000, 32'h2800_0000, 32'h2C00_0000};
	logic [1:0]   xv [4] = '{2'b01, 2'b00, 2'b10, 2'b00};
	int           num_errors = 0;
	int           check_count = 0;
	svrf_partner p (.core_clk, .vwr, .vrd, .lsu_ld(ld), .fp, .issue_valid(iv));
	svrf_vector_regfile uut (.core_clk, .rst_n, .bus, .bus_rdata, .vwr, .vrd,
		.vrd_rsp(rsp), .lsu_ld(ld), .fp, .fp_rd_valid(fpv), .fp_rd_data(fpd),
		.issue_valid(iv), .exc_valid(exv), .exc_reserved(exr), .exc_disabled(exd),
		.big_endian_flag(bef), .fpu_wide_reg_mode(frm), .regs_undefined(und));
	// Free-running core clock.
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic ck(input string n, input logic [127:0] x, input logic [127:0] g);
		check_count++;
		if (g !== x) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic bw(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		bus <= '{1'b1, 1'b0, a, v};
		@(posedge core_clk);
		bus <= '0;
	endtask
	// Read data stand only in the slot after the strobe.
	task automatic br(input logic [7:0] a, input logic [31:0] x);
		@(posedge core_clk);
		bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge core_clk);
		bus <= '0;
		#1;
		ck("rdata", x, bus_rdata);
	endtask
	// Lowest (k=0) or highest (k=1) element and slide row.
	task automatic rv(input logic [4:0] a, input int f, input logic k);
		p.vr('{1'b1, a, svrf_fmt_e'(f), k ? 4'hF : 4'h0, k ? 3'((1 << f) - 1) : 3'h0});
		#1;
	endtask
	function automatic logic [127:0] sw(input logic [127:0] v, input int f);
		for (int j = 0; j < 16; j++)
			sw[j*8 +: 8] = v[(j ^ ((1 << f) - 1))*8 +: 8];
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int j = 0; j < 16; j++)
			d[j*8 +: 8] = 8'(j + 16);
		// Reset state, a refused capability write and an unmapped place.
		br(ADDR_CTRL, CTRL_RESET);
		bw(ADDR_CAP, 32'h0);
		br(ADDR_CAP, 32'h104C_0000);
		br(8'h40, 32'h0);
		$display("test registers done");
		p.vw('{1'b1, 5'd31, d, BE_ALL});
		p.vw('{1'b1, 5'd0, ~d, 16'h00FF});
		rv(5'd0, 0, 1'b0);
		ck("vec0", {64'h0, ~d[63:0]}, rsp.vec);
		ck("vvalid", 128'h1, rsp.valid);
		for (int f = 0; f < 4; f++)
			for (int k = 0; k < 2; k++) begin
				rv(5'd31, f, k[0]);
				e = d >> (k ? 128 - (8 << f) : 0);
				ck("elem", e & ((128'h1 << (8 << f)) - 1), rsp.elem);
				e = d >> (k ? 128 - (128 >> f) : 0);
				ck("slide", e & ((128'h1 << (128 >> f)) - 1), rsp.slide);
				ck("mem", d, rsp.mem);
			end
		// Big-endian images swap bytes inside each element only.
		bw(ADDR_CTRL, 32'h0000_8000);
		for (int f = 0; f < 4; f++) begin
			rv(5'd31, f, 1'b0);
			ck("mem_be", sw(d, f), rsp.mem);
		end
		ck("bef", 128'h1, bef);
		p.ld('{1'b1, 5'd7, FMT_WORD, d});
		rv(5'd7, 2, 1'b0);
		ck("load", sw(d, 2), rsp.vec);
		$display("test layout done");
		// Wide mode flags the file; scalar writes then patch the low words.
		bw(ADDR_CTRL, 32'h0400_0000);
		br(ADDR_STATUS, 32'h1);
		ck("frm", 128'h1, frm);
		ck("und", 128'h1, und);
		bw(ADDR_STATUS, 32'h1);
		br(ADDR_STATUS, 32'h0);
		e = {d[127:64], 64'h1122_3344_5566_7788};
		p.fo('{1'b0, 1'b1, 5'd31, FP_DOUBLE, e[63:0]});
		p.fo('{1'b0, 1'b1, 5'd31, FP_HIGH, 64'hAABB_CCDD});
		e[63:32] = 32'hAABB_CCDD;
		rv(5'd31, 0, 1'b0);
		ck("vec_fp", e, rsp.vec);
		p.fo('{1'b1, 1'b0, 5'd31, FP_DOUBLE, 64'h0});
		#1;
		ck("fp_dbl", e[63:0], fpd);
		ck("fpv", 128'h1, fpv);
		p.fo('{1'b1, 1'b0, 5'd31, FP_HIGH, 64'h0});
		#1;
		ck("fp_hi", e[63:32], fpd[31:0]);
		// A single write touches word 0 only; the high word must survive it.
		p.fo('{1'b0, 1'b1, 5'd31, FP_SINGLE, 64'hFFFF_FFFF_0BAD_F00D});
		e[31:0] = 32'h0BAD_F00D;
		p.fo('{1'b1, 1'b0, 5'd31, FP_SINGLE, 64'h0});
		#1;
		ck("fp_sgl", e[31:0], fpd);
		rv(5'd31, 0, 1'b0);
		ck("vec_sgl", e, rsp.vec);
		$display("test scalar done");
		// Four mode combinations seen by an issued vector instruction.
		for (int i = 0; i < 4; i++) begin
			bw(ADDR_CTRL, cv[i]);
			p.iss();
			#1;
			ck("exc", {1'b1, xv[i]}, {exv, exr, exd});
		end
		$display("test exceptions done");
		end_sim();
	end
endmodule // tb
`default_nettype wire

// [design/svrf_lane_unit.sv]
// Purpose: Element and slide-row views of one vector register value.
// Assumes: Purely combinational; the caller registers the results.
// Notes: Unused index bits for wide formats are ignored.
`timescale 1ns/1ns
`default_nettype none
module svrf_lane_unit
	import svrf_pkg::*;
(
	input  wire logic [VEC_W-1:0] vec,
	input  wire svrf_fmt_e        fmt,
	input  wire logic [3:0]       idx,
	input  wire logic [2:0]       row,
	output var  logic [FP_W-1:0]  elem,
	output var  logic [VEC_W-1:0] slide
);

	// Element i of width w starts at bit i*w; the row select mirrors it.
	always_comb begin
		elem  = '0;
		slide = '0;
		case (fmt)
			FMT_BYTE: begin
				elem[7:0] = vec[{idx, 3'b000} +: 8]; // [RQ4] [RQ5] [RQ6]
				slide     = vec; // [RQ7]
			end
			FMT_HALF: begin
				elem[15:0]  = vec[{idx[2:0], 4'h0} +: 16]; // [RQ6]
				slide[63:0] = vec[{row[0], 6'h00} +: 64]; // [RQ7]
			end
			FMT_WORD: begin
				elem[31:0]  = vec[{idx[1:0], 5'h00} +: 32]; // [RQ6]
				slide[31:0] = vec[{row[1:0], 5'h00} +: 32]; // [RQ7]
			end
			default: begin
				elem        = vec[{idx[0], 6'h00} +: 64]; // [RQ4] [RQ6]
				slide[15:0] = vec[{row, 4'h0} +: 16]; // [RQ7]
			end
		endcase
	end

endmodule // svrf_lane_unit
`default_nettype wire

// [design/svrf_pkg.sv]
// Purpose: Shared constants, carriers and helpers for the SIMD vector register file.
// Assumes: All request inputs come from logic on core_clk; no synchronisers needed.
// Notes:
// Operation
// RQ1 - Thirty-two vector registers, 128 bits each, selected by a 5-bit index.
// RQ2 - Scalar FPU registers live in the low part of the same vector register.
// RQ3 - Coexisting FPU has 64-bit registers; its capability flag bit 22 reads one.
// RQ4 - Byte, halfword, word and doubleword elements: 16, 8, 4 and 2 per register.
// RQ5 - Element 0 starts at bit 0; the top element ends at bit 127.
// RQ6 - Element i of width w occupies bits i*w up to i*w+w-1.
// RQ7 - Slide view: one byte row per element byte; row 0 holds lowest bytes.
// RQ8 - Memory image puts element 0 lowest; byte order follows the endian flag.
// RQ9 - Word byte k of element i sits at 4i+k little, 4i+3-k big endian.
// RQ10 - With both units present, NaN and abs compliance flags 18 and 19 read one.
// RQ11 - Vector instruction with coproc usable set and wide mode clear: reserved.
// RQ12 - Scalar read returns element 0 as a word or doubleword.
// RQ13 - Scalar high-half read returns word element 1.
// RQ14 - Scalar write stores into element 0 at word or doubleword width.
// RQ15 - High-half write stores word element 1 and keeps word element 0.
// RQ16 - Any wide-mode change makes all register contents undefined.
// RQ17 - Vector instruction with enable bit clear raises disabled; enable resets zero.
// RQ18 - Present flag is fixed; when clear every vector instruction is reserved.
// RQ19 - Undefined bits after a scalar write simply keep their old contents.
// RQ20 - Byte-granular write enables over all 128 bits.
package svrf_pkg;

	localparam int NUM_REGS = 32;
	localparam int VEC_W    = 128;
	localparam int VEC_B    = 16;
	localparam int FP_W     = 64;

	// Software-visible register offsets and field positions.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_CAP    = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam int BIT_BE      = 15;
	localparam int BIT_FR      = 26;
	localparam int BIT_EN      = 27;
	localparam int BIT_CU1     = 29;
	localparam int BIT_PRESENT = 28;
	localparam int BIT_F64     = 22;
	localparam int BIT_NAN     = 18;
	localparam int BIT_ABS     = 19;
	localparam int BIT_UNDEF   = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Byte enables of the scalar write kinds, plus the full-register enable.
	localparam logic [15:0] BE_SINGLE = 16'h000F;
	localparam logic [15:0] BE_DOUBLE = 16'h00FF;
	localparam logic [15:0] BE_HIGH   = 16'h00F0;
	localparam logic [15:0] BE_ALL    = 16'hFFFF;

	typedef enum logic [1:0] {FMT_BYTE, FMT_HALF, FMT_WORD, FMT_DWORD} svrf_fmt_e;
	typedef enum logic [1:0] {FP_SINGLE, FP_DOUBLE, FP_HIGH} svrf_fpk_e;

	typedef struct packed {
		logic             wr;
		logic             rd;
		logic [7:0]       addr;
		logic [31:0]      wdata;
	} svrf_bus_s;

	typedef struct packed {
		logic             en;
		logic [4:0]       addr;
		logic [VEC_W-1:0] data;
		logic [VEC_B-1:0] be;
	} svrf_vwr_s;

	typedef struct packed {
		logic             en;
		logic [4:0]       addr;
		svrf_fmt_e        fmt;
		logic [3:0]       idx;
		logic [2:0]       row;
	} svrf_vrd_s;

	typedef struct packed {
		logic             valid;
		logic [VEC_W-1:0] vec;
		logic [FP_W-1:0]  elem;
		logic [VEC_W-1:0] mem;
		logic [VEC_W-1:0] slide;
	} svrf_rsp_s;

	typedef struct packed {
		logic             en;
		logic [4:0]       addr;
		svrf_fmt_e        fmt;
		logic [VEC_W-1:0] mem;
	} svrf_ld_s;

	typedef struct packed {
		logic             rd;
		logic             wr;
		logic [4:0]       addr;
		svrf_fpk_e        kind;
		logic [FP_W-1:0]  wdata;
	} svrf_fp_s;

	// Swapping bytes inside each element is its own inverse, so one helper
	// serves both the store image and the load path.
	function automatic logic [VEC_W-1:0] svrf_swap(input logic [VEC_W-1:0] v,
		input svrf_fmt_e fmt, input logic big);
		logic [VEC_W-1:0] o;
		logic [3:0]       m;
		o = '0;
		m = big ? ((4'h1 << fmt) - 4'h1) : 4'h0;
		for (int j = 0; j < VEC_B; j++) begin
			o[j*8 +: 8] = v[(4'(j) ^ m)*8 +: 8]; // [RQ8] [RQ9]
		end
		return o;
	endfunction

endpackage

// [design/svrf_vector_regfile.sv]
// Purpose: Thirty-two entry 128-bit vector register file with scalar FPU overlay.
// Assumes: Pipeline, FPU and load/store requests are synchronous to core_clk.
// Notes: Reads see the contents before any write in the same cycle.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module svrf_vector_regfile
	import svrf_pkg::*;
#(
	parameter logic SIMD_PRESENT = 1'b1,
	parameter logic FPU_PRESENT  = 1'b1
) (
	input  wire logic      core_clk,
	input  wire logic      rst_n,
	input  wire svrf_bus_s bus,
	output var  logic [31:0] bus_rdata,
	input  wire svrf_vwr_s vwr,
	input  wire svrf_vrd_s vrd,
	output var  svrf_rsp_s vrd_rsp,
	input  wire svrf_ld_s  lsu_ld,
	input  wire svrf_fp_s  fp,
	output var  logic      fp_rd_valid,
	output var  logic [FP_W-1:0] fp_rd_data,
	input  wire logic      issue_valid,
	output var  logic      exc_valid,
	output var  logic      exc_reserved,
	output var  logic      exc_disabled,
	output var  logic      big_endian_flag,
	output var  logic      fpu_wide_reg_mode,
	output var  logic      regs_undefined
);

	// Whole module state in one packed record.
	typedef struct packed {
		logic [NUM_REGS-1:0][VEC_W-1:0] regs;
		logic             big_endian_flag;
		logic             fpu_wide_reg_mode;
		logic             simd_enable_flag;
		logic             coproc1_usable;
		logic             regs_undefined;
		logic [31:0]      bus_rdata;
		svrf_rsp_s        rsp;
		logic             fp_rd_valid;
		logic [FP_W-1:0]  fp_rd_data;
		logic             exc_valid;
		logic             exc_reserved;
		logic             exc_disabled;
	} svrf_state_s;

	svrf_state_s      st;
	svrf_state_s      next_st;
	logic [FP_W-1:0]  lane_elem;
	logic [VEC_W-1:0] lane_slide;
	logic [VEC_W-1:0] rd_vec;
	svrf_vwr_s        wr_req [3];
	logic             ctrl_wr;
	logic             fr_change;
	logic             reserved;

	// The read port looks at the settled array, before this cycle's writes.
	assign rd_vec = st.regs[vrd.addr];

	svrf_lane_unit u_lane (
		.vec   (rd_vec),
		.fmt   (vrd.fmt),
		.idx   (vrd.idx),
		.row   (vrd.row),
		.elem  (lane_elem),
		.slide (lane_slide)
	);

	// Capability word: read-only flags fixed by the build parameters.
	function automatic logic [31:0] cap_word();
		logic [31:0] w;
		w = '0;
		w[BIT_PRESENT] = SIMD_PRESENT; // [RQ18]
		w[BIT_F64]     = FPU_PRESENT; // [RQ3]
		w[BIT_NAN]     = FPU_PRESENT & SIMD_PRESENT; // [RQ10]
		w[BIT_ABS]     = FPU_PRESENT & SIMD_PRESENT; // [RQ10]
		return w;
	endfunction

	// Control word as software sees it.
	function automatic logic [31:0] ctrl_word(input svrf_state_s s);
		logic [31:0] w;
		w = '0;
		w[BIT_BE]  = s.big_endian_flag;
		w[BIT_FR]  = s.fpu_wide_reg_mode;
		w[BIT_EN]  = s.simd_enable_flag;
		w[BIT_CU1] = s.coproc1_usable;
		return w;
	endfunction

	// Scalar writes become an ordinary byte-enabled vector write, so the
	// untouched elements keep their value rather than needing a clear path.
	always_comb begin
		wr_req[0] = vwr;
		wr_req[1].en   = lsu_ld.en;
		wr_req[1].addr = lsu_ld.addr;
		wr_req[1].data = svrf_swap(lsu_ld.mem, lsu_ld.fmt, st.big_endian_flag); // [RQ8]
		wr_req[1].be   = BE_ALL;
		wr_req[2].en   = fp.wr;
		wr_req[2].addr = fp.addr; // [RQ2]
		wr_req[2].data = '0;
		wr_req[2].be   = BE_DOUBLE;
		case (fp.kind)
			FP_SINGLE: begin
				wr_req[2].data[31:0] = fp.wdata[31:0]; // [RQ14]
				wr_req[2].be         = BE_SINGLE; // [RQ19]
			end
			FP_HIGH: begin
				wr_req[2].data[63:32] = fp.wdata[31:0]; // [RQ15]
				wr_req[2].be          = BE_HIGH; // [RQ15] [RQ19]
			end
			default: begin
				wr_req[2].data[63:0] = fp.wdata; // [RQ14]
				wr_req[2].be         = BE_DOUBLE; // [RQ19]
			end
		endcase
	end

	// Reserved wins over disabled: an absent or mode-mismatched unit must
	// never appear to software as merely switched off.
	assign reserved = !SIMD_PRESENT
		|| (st.coproc1_usable && !st.fpu_wide_reg_mode); // [RQ11] [RQ18]

	assign ctrl_wr   = bus.wr && (bus.addr == ADDR_CTRL);
	assign fr_change = ctrl_wr && (bus.wdata[BIT_FR] != st.fpu_wide_reg_mode);

	// Next-state logic for every field of the state record.
	always_comb begin
		next_st = st;
		next_st.rsp.valid   = 1'b0;
		next_st.fp_rd_valid = 1'b0;
		next_st.exc_valid   = 1'b0;
		next_st.bus_rdata   = '0;

		// Register bus writes; unmapped addresses are ignored.
		if (ctrl_wr) begin
			next_st.big_endian_flag   = bus.wdata[BIT_BE];
			next_st.fpu_wide_reg_mode = bus.wdata[BIT_FR];
			next_st.simd_enable_flag  = bus.wdata[BIT_EN];
			next_st.coproc1_usable    = bus.wdata[BIT_CU1];
		end else if (bus.wr && (bus.addr == ADDR_STATUS)) begin
			if (bus.wdata[BIT_UNDEF]) begin
				next_st.regs_undefined = 1'b0;
			end
		end

		// A mode change in the same cycle as the clear still leaves the flag set.
		if (fr_change) begin
			next_st.regs_undefined = 1'b1; // [RQ16]
		end

		// Register bus reads; unmapped addresses read zero.
		if (bus.rd) begin
			if (bus.addr == ADDR_CTRL) begin
				next_st.bus_rdata = ctrl_word(st);
			end else if (bus.addr == ADDR_CAP) begin
				next_st.bus_rdata = cap_word(); // [RQ3] [RQ10] [RQ18]
			end else if (bus.addr == ADDR_STATUS) begin
				next_st.bus_rdata[BIT_UNDEF] = st.regs_undefined;
			end
		end

		// Writes apply in order pipeline, load, scalar; later ones win per byte.
		for (int w = 0; w < 3; w++) begin
			if (wr_req[w].en) begin
				for (int b = 0; b < VEC_B; b++) begin
					if (wr_req[w].be[b]) begin
						next_st.regs[wr_req[w].addr][b*8 +: 8] =
							wr_req[w].data[b*8 +: 8]; // [RQ1] [RQ20]
					end
				end
			end
		end

		// Vector read: raw value, element, memory image and slide row.
		if (vrd.en) begin
			next_st.rsp.valid = 1'b1;
			next_st.rsp.vec   = rd_vec; // [RQ1]
			next_st.rsp.elem  = lane_elem; // [RQ6]
			next_st.rsp.mem   = svrf_swap(rd_vec, vrd.fmt, st.big_endian_flag); // [RQ8] [RQ9]
			next_st.rsp.slide = lane_slide; // [RQ7]
		end

		// Scalar read of element 0 or of word element 1.
		if (fp.rd) begin
			next_st.fp_rd_valid = 1'b1;
			next_st.fp_rd_data  = '0;
			case (fp.kind)
				FP_SINGLE: begin
					next_st.fp_rd_data[31:0] = st.regs[fp.addr][31:0]; // [RQ12]
				end
				FP_HIGH: begin
					next_st.fp_rd_data[31:0] = st.regs[fp.addr][63:32]; // [RQ13]
				end
				default: begin
					next_st.fp_rd_data = st.regs[fp.addr][63:0]; // [RQ2] [RQ12]
				end
			endcase
		end

		// Instruction legality check, answered one cycle after issue.
		if (issue_valid) begin
			next_st.exc_valid    = 1'b1;
			next_st.exc_reserved = reserved; // [RQ11] [RQ18]
			next_st.exc_disabled = !reserved && !st.simd_enable_flag; // [RQ17]
		end
	end

	// State register; reset clears everything, including the enable bit.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st <= '0; // [RQ17]
		end else begin
			st <= next_st;
		end
	end

	// Every output is a direct copy of a state field.
	assign bus_rdata         = st.bus_rdata;
	assign vrd_rsp           = st.rsp;
	assign fp_rd_valid       = st.fp_rd_valid;
	assign fp_rd_data        = st.fp_rd_data;
	assign exc_valid         = st.exc_valid;
	assign exc_reserved      = st.exc_reserved;
	assign exc_disabled      = st.exc_disabled;
	assign big_endian_flag   = st.big_endian_flag;
	assign fpu_wide_reg_mode = st.fpu_wide_reg_mode;
	assign regs_undefined    = st.regs_undefined;

endmodule // svrf_vector_regfile
`default_nettype wire
